// ===== common/ess_pkg.sv
package ess_pkg;
  // Register port offsets
  localparam logic [11:0] COMMIT_OFS = 12'h232;
  localparam logic [11:0] LIST_BASE = 12'ha00;
  localparam logic [11:0] LIST_LAST = 12'haff;
  localparam logic [11:0] BUSY_OFS = 12'hb00;
  localparam logic [11:0] LOAD_CTL_OFS = 12'hb02;
  localparam logic [11:0] SAVE_CTL_OFS = 12'hb03;
  // Field positions
  localparam int COMMIT_BIT = 0;
  localparam int BUSY_BIT = 0;
  localparam int WR_EN_BIT = 0;
  localparam int SOFT_LOAD_BIT = 1;
  localparam int SAVE_BIT = 0;
  localparam int OPCODE_BIT = 7;
  // Reset values
  localparam logic WR_EN_RST = 1'h0;
  // Operation codes (low seven bits of an opcode byte)
  localparam logic [6:0] OPC_COMMIT_DEF = 7'h01;
  localparam logic [6:0] OPC_END_DEF = 7'h7f;
  // Power-on list: one 128-byte data entry from address 0, commit, end
  localparam logic [7:0] DEF_LEN_M1 = 8'h7f;
  localparam logic [7:0] DEF_ADDR_HI = 8'h00;
  localparam logic [7:0] DEF_ADDR_LO = 8'h00;
  // Least pause between transfers, imposed on the host
  localparam int GAP_NS = 10000;
  localparam int CLK_NS = 40;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;

  // One byte move handed to the memory controller
  typedef struct packed {
    logic save;
    logic [15:0] addr;
  } ess_req_t;
endpackage : ess_pkg

// ===== verilog/ess_sequencer.sv
`timescale 1ns/1ns
module ess_sequencer #(
  parameter logic [6:0] OPC_COMMIT = ess_pkg::OPC_COMMIT_DEF,
  parameter logic [6:0] OPC_END = ess_pkg::OPC_END_DEF,
  parameter int LIST_DEPTH = 256
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port from the serial control port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Memory-select pin
  input wire logic mem_sel_b,
  // Buffer-to-active copy strobe and soft reset
  output logic commit_strobe,
  output logic soft_reset,
  // Byte move requests to the memory controller
  output logic req_valid,
  input wire logic req_ready,
  output ess_pkg::ess_req_t req
);

  if (OPC_COMMIT == OPC_END || LIST_DEPTH != 256)
  begin : g_bad_cfg
    $error("ess_sequencer: opcodes must differ and list must be 256 bytes");
  end

  typedef enum {ESS_IDLE, ESS_CMD, ESS_ADDR_HI, ESS_ADDR_LO, ESS_MOVE, ESS_DRAIN} ess_state_t;

  // Power-on list contents
  function automatic logic [7:0] ess_default(input logic [7:0] idx);
    logic [7:0] val;
    val = {1'b1, OPC_END};
    if (idx == 8'h00)
      val = ess_pkg::DEF_LEN_M1;
    else if (idx == 8'h01)
      val = ess_pkg::DEF_ADDR_HI;
    else if (idx == 8'h02)
      val = ess_pkg::DEF_ADDR_LO;
    else if (idx == 8'h03)
      val = {1'b1, OPC_COMMIT};
    return val;
  endfunction : ess_default

  logic [7:0] cmd_list [LIST_DEPTH];
  ess_state_t state;
  logic [7:0] ptr;
  logic [6:0] cnt;
  logic [15:0] addr;
  logic [7:0] addr_hi;
  logic save_mode;
  logic commit_pend;
  logic busy;
  logic wr_en;
  logic soft_pend;
  ess_pkg::ess_req_t slot [2];
  logic [1:0] fill;
  logic rd_idx;

  // Register decode
  wire hit_commit = reg_addr == ess_pkg::COMMIT_OFS;
  wire hit_list = reg_addr >= ess_pkg::LIST_BASE && reg_addr <= ess_pkg::LIST_LAST;
  wire hit_busy = reg_addr == ess_pkg::BUSY_OFS;
  wire hit_load = reg_addr == ess_pkg::LOAD_CTL_OFS;
  wire hit_save = reg_addr == ess_pkg::SAVE_CTL_OFS;
  wire [7:0] list_idx = reg_addr[7:0];
  wire host_commit = reg_wr && hit_commit && reg_wdata[ess_pkg::COMMIT_BIT];
  wire start_save = reg_wr && hit_save && reg_wdata[ess_pkg::SAVE_BIT] && wr_en && !busy;
  wire start_load = reg_wr && hit_load && reg_wdata[ess_pkg::SOFT_LOAD_BIT] && !mem_sel_b
    && !busy;

  // List byte decode at the walk pointer
  wire [7:0] cur = cmd_list[ptr];
  wire is_op = cur[ess_pkg::OPCODE_BIT];
  wire op_commit = is_op && cur[6:0] == OPC_COMMIT && ptr != 8'hff;
  wire op_end = (is_op && !op_commit) || ptr == 8'hff;
  wire list_commit = state == ESS_CMD && op_commit;

  // Two-entry buffer handshakes
  wire buf_in_ready = fill != 2'd2;
  wire push = state == ESS_MOVE && buf_in_ready;
  wire pop = req_valid && req_ready;
  wire [7:0] next_ptr = ptr + 8'd1;
  assign req_valid = fill != 2'd0;
  assign req = slot[rd_idx];

  // Command list storage with power-on contents
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      for (int i = 0; i < LIST_DEPTH; i++)
        cmd_list[i] <= ess_default(8'(i));
    else if (reg_wr && hit_list)
      cmd_list[list_idx] <= reg_wdata;
  end

  // Commit pending bit, set one edge after the cause and driven straight out as the strobe
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      commit_pend <= 1'b0;
    else
      commit_pend <= host_commit || list_commit;
  end
  assign commit_strobe = commit_pend;

  // Host control bits
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_en <= ess_pkg::WR_EN_RST;
      soft_pend <= 1'b0;
    end
    else
    begin
      if (reg_wr && hit_load)
        wr_en <= reg_wdata[ess_pkg::WR_EN_BIT];
      soft_pend <= start_load;
    end
  end
  assign soft_reset = soft_pend;

  // List walker
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ESS_IDLE;
      ptr <= 8'h00;
      cnt <= 7'h00;
      addr <= 16'h0000;
      addr_hi <= 8'h00;
      save_mode <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      unique case (state)
        ESS_IDLE:
        if (start_save || start_load)
        begin
          save_mode <= start_save;
          ptr <= 8'h00;
          busy <= 1'b1;
          state <= ESS_CMD;
        end
        ESS_CMD:
        if (op_end)
          state <= ESS_DRAIN;
        else
        begin
          ptr <= next_ptr;
          if (!is_op)
          begin
            cnt <= cur[6:0];
            state <= ESS_ADDR_HI;
          end
        end
        ESS_ADDR_HI:
        begin
          addr_hi <= cur;
          ptr <= next_ptr;
          state <= ptr == 8'hff ? ESS_DRAIN : ESS_ADDR_LO;
        end
        ESS_ADDR_LO:
        begin
          addr <= {addr_hi, cur};
          ptr <= next_ptr;
          state <= ptr == 8'hff ? ESS_DRAIN : ESS_MOVE;
        end
        ESS_MOVE:
        if (push)
        begin
          addr <= addr + 16'h0001;
          cnt <= cnt - 7'h01;
          if (cnt == 7'h00)
            state <= ESS_CMD;
        end
        ESS_DRAIN:
        if (fill == 2'd0)
        begin
          busy <= 1'b0;
          state <= ESS_IDLE;
        end
      endcase
    end
  end

  // Two-entry request buffer
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fill <= 2'd0;
      rd_idx <= 1'b0;
      slot[0] <= '0;
      slot[1] <= '0;
    end
    else
    begin
      if (push)
        slot[rd_idx ^ fill[0]] <= '{save: save_mode, addr: addr};
      if (pop)
        rd_idx <= ~rd_idx;
      fill <= fill + {1'b0, push} - {1'b0, pop};
    end
  end

  // Register read data
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (hit_list)
        reg_rdata <= cmd_list[list_idx];
      else if (hit_commit)
        reg_rdata <= {7'h00, commit_pend};
      else if (hit_busy)
        reg_rdata <= {7'h00, busy};
      else if (hit_load)
        reg_rdata <= {6'h00, soft_pend, wr_en};
      else if (hit_save)
        reg_rdata <= {7'h00, busy && save_mode};
      else
        reg_rdata <= 8'h00;
    end
  end

  // Checks
  default clocking ck @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Host commit with no fresh cause in the strobe cycle
  sequence s_host_commit;
    host_commit && !list_commit ##1 !(host_commit || list_commit);
  endsequence
  sequence s_strobe_then_clear;
    commit_strobe ##1 !commit_strobe;
  endsequence

  a_commit_one_edge: assert property (s_host_commit |-> s_strobe_then_clear)
    else $error("commit strobe not one edge after write");
  a_commit_cause: assert property (commit_strobe |->
    $past(host_commit) || $past(list_commit))
    else $error("commit strobe without cause");
  a_list_commit_op: assert property (state == ESS_CMD && op_commit |=> commit_strobe)
    else $error("commit opcode did not commit");
  a_walk_starts_zero: assert property ($rose(busy) |-> ptr == 8'h00 && state == ESS_CMD)
    else $error("walk did not start at first byte");
  a_data_cmd_len: assert property (state == ESS_CMD && !is_op && !op_end |=>
    state == ESS_ADDR_HI && cnt == $past(cur[6:0]))
    else $error("transfer length not taken");
  a_addr_msb_first: assert property (state == ESS_ADDR_HI |=>
    state == ESS_DRAIN or (state == ESS_ADDR_LO ##1 addr[15:8] == $past(addr_hi)))
    else $error("address byte order wrong");
  a_end_stops: assert property (state == ESS_CMD && op_end |=> state == ESS_DRAIN)
    else $error("end opcode did not stop walk");
  a_busy_drain: assert property (state == ESS_DRAIN && fill == 2'd0 |=> !busy)
    else $error("busy not cleared after drain");
  a_buf_no_overfill: assert property (state == ESS_MOVE && fill == 2'd2 |=> $stable(addr))
    else $error("request skipped while buffer full");
  a_soft_load_pin: assert property (soft_reset |-> $past(!mem_sel_b))
    else $error("soft load with select high");
endmodule : ess_sequencer

// ===== bench/ess_mem_model.sv
`timescale 1ns/1ns
module ess_mem_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Request stream
  input wire logic req_valid,
  input wire ess_pkg::ess_req_t req,
  output logic req_ready
);
  ess_pkg::ess_req_t got[$];
  // Ready on alternate cycles, so the buffer fills and stalls
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      req_ready <= 1'b0;
    else
    begin
      if (req_valid && req_ready)
        got.push_back(req);
      req_ready <= ~req_ready;
    end
  end
endmodule : ess_mem_model

// ===== bench/tb_top.sv
`timescale 1ns/1ns
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("Error %s exp %h got %h", n, e, a); end end
module tb_top;
  logic sys_clk, rst_b, reg_wr, reg_rd, mem_sel_b;
  logic commit_strobe, soft_reset, req_valid, req_ready;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_val;
  ess_pkg::ess_req_t req;
  int fail_count, comparisons, strobes, resets;

  ess_sequencer u_ess_sequencer (.sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .mem_sel_b(mem_sel_b), .commit_strobe(commit_strobe), .soft_reset(soft_reset),
    .req_valid(req_valid), .req_ready(req_ready), .req(req));
  ess_mem_model u_ess_mem_model (.sys_clk(sys_clk), .rst_b(rst_b), .req_valid(req_valid),
    .req(req), .req_ready(req_ready));

  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Pulse counters
  always @(posedge sys_clk)
  begin
    if (commit_strobe === 1'b1)
      strobes++;
    if (soft_reset === 1'b1)
      resets++;
  end

  task automatic close_out;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    rd_val = reg_rdata;
  endtask : rd

  task automatic wait_idle;
    int n;
    n = 0;
    rd(ess_pkg::BUSY_OFS);
    while (rd_val[0] !== 1'b0 && n < 1000)
    begin
      rd(ess_pkg::BUSY_OFS);
      n++;
    end
    if (rd_val[0] !== 1'b0)
    begin
      fail_count++;
      close_out();
    end
  endtask : wait_idle

  task automatic check_idle;
    rd(ess_pkg::COMMIT_OFS);
    `CHK("commit rd", 8'h00, rd_val)
    rd(ess_pkg::LIST_BASE - 12'h001);
    `CHK("unmapped", 8'h00, rd_val)
    wr(ess_pkg::SAVE_CTL_OFS, 8'h01);
    wr(ess_pkg::LOAD_CTL_OFS, 8'h02);
    rd(ess_pkg::BUSY_OFS);
    `CHK("busy locked", 8'h00, rd_val)
    `CHK("req locked", 0, u_ess_mem_model.got.size())
    `CHK("load locked", 0, resets)
  endtask : check_idle

  task automatic check_commit;
    strobes = 0;
    wr(ess_pkg::COMMIT_OFS, 8'h01);
    `CHK("strobe", 1'b1, commit_strobe)
    @(negedge sys_clk);
    `CHK("strobe off", 1'b0, commit_strobe)
    rd(ess_pkg::COMMIT_OFS);
    `CHK("commit clr", 8'h00, rd_val)
    wr(ess_pkg::COMMIT_OFS, 8'h00);
    `CHK("zero write", 1, strobes)
  endtask : check_commit

  task automatic check_default_save;
    strobes = 0;
    wr(ess_pkg::LOAD_CTL_OFS, 8'h01);
    wr(ess_pkg::SAVE_CTL_OFS, 8'h01);
    rd(ess_pkg::SAVE_CTL_OFS);
    `CHK("save bit", 8'h01, rd_val)
    rd(ess_pkg::BUSY_OFS);
    `CHK("busy", 8'h01, rd_val)
    wait_idle();
    `CHK("save count", 128, u_ess_mem_model.got.size())
    for (int i = 0; i < 128; i++)
      `CHK("save req", {1'b1, 16'(i)}, u_ess_mem_model.got[i])
    `CHK("list commit", 1, strobes)
    rd(ess_pkg::SAVE_CTL_OFS);
    `CHK("save clr", 8'h00, rd_val)
  endtask : check_default_save

  task automatic check_custom_load;
    repeat (ess_pkg::GAP_CYC) @(negedge sys_clk);
    wr(ess_pkg::LIST_BASE, 8'h01);
    wr(ess_pkg::LIST_BASE + 12'h001, 8'h12);
    wr(ess_pkg::LIST_BASE + 12'h002, 8'h34);
    wr(ess_pkg::LIST_BASE + 12'h003, 8'h85);
    wr(ess_pkg::LIST_BASE + 12'h004, {1'b1, ess_pkg::OPC_COMMIT_DEF});
    wr(ess_pkg::LIST_LAST, {1'b1, ess_pkg::OPC_END_DEF});
    rd(ess_pkg::LIST_BASE + 12'h003);
    `CHK("list rd", 8'h85, rd_val)
    u_ess_mem_model.got.delete();
    strobes = 0;
    resets = 0;
    mem_sel_b = 1'b0;
    wr(ess_pkg::LOAD_CTL_OFS, 8'h03);
    wait_idle();
    `CHK("soft reset", 1, resets)
    `CHK("load count", 2, u_ess_mem_model.got.size())
    `CHK("load req0", {1'b0, 16'h1234}, u_ess_mem_model.got[0])
    `CHK("load req1", {1'b0, 16'h1235}, u_ess_mem_model.got[1])
    `CHK("stop walk", 0, strobes)
  endtask : check_custom_load

  // Main sequence
  initial
  begin
    fail_count = 0;
    comparisons = 0;
    strobes = 0;
    resets = 0;
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    rd_val = 8'h00;
    mem_sel_b = 1'b1;
    repeat (6) @(negedge sys_clk);
    rst_b = 1'b1;
    check_idle();
    check_commit();
    check_default_save();
    check_custom_load();
    close_out();
  end
endmodule : tb_top
